// >>> logic/flash_isp_status_regs.sv
/*
  Flash programming status and configuration registers with the trigger
  sequencer, fail checks and vector page remap, behind an APB slave.
  Assumes the flash core pulses op_done after each op_start and that
  protection_unlock comes from the system protection logic on pclk.
*/
// Chosen here: the APB interface to the registers.
// Functional notes
// [R1] data flash start register is 32-bit read only; writes are ignored
// [R2] 128 KB part loads data flash start from config word 1 at power-on
// [R3] 64/32 KB parts read data flash start as fixed 0x0001_F000
// [R4] access-time register bit 4 enables low frequency optimization
// [R5] software sets low frequency optimization only below 25 MHz
// [R6] low frequency optimization bit writable only while unlocked
// [R7] addresses 0 to 0x1FF redirect to vector map page plus nine bits
// [R8] vector map status field is read only, shows active mapping
// [R9] fail flag bit 6 set when application or loader writes itself; the code sets it only while that region's update bit is clear
// [R10] fail flag set on config erase/program without update enable
// [R11] fail flag set when destination address is illegal
// [R12] fail flag cleared only by software writing 1, while unlocked
// [R13] status fail flag and control bit 6 are one flag
// [R14] status bits 2:1 mirror boot selection of config word 0
// [R15] status bit 0 reads 1 during operation, cleared on finish
// [R16] status bit 0 read only, mirrors trigger register bit 0
// [R17] software unlocks protection with 0x59, 0x16, 0x88 uninterrupted
// [R18] setting trigger starts operation; hardware self-clears it on done
// [R19] remap command 0x2E targets page-aligned application/loader page
// [R20] successful remap loads vector map with target address bits 20:9
`timescale 1ns/1ns
module flash_isp_status_regs
  import flash_isp_pkg::*;
#(
  parameter int FLASH_KB = 128
) (
  input  wire logic        pclk,              // system clock
  input  wire logic        presetn,           // async reset, active low
  input  wire logic        clk_en,            // freezes all state when low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [7:0]  paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error, unmapped
  input  wire logic        protection_unlock, // protected bits writable
  input  wire logic [31:0] user_config_word0, // config word 0
  input  wire logic [31:0] user_config_word1, // config word 1
  input  wire logic        running_from_loader, // cpu runs loader flash
  input  wire logic        op_done,           // flash core finished
  input  wire logic [31:0] fetch_addr,        // cpu flash address
  output logic      [31:0] flash_phys_addr,   // remapped flash address
  output logic             op_start,          // start pulse to core
  output logic      [5:0]  op_command,        // command to core
  output logic      [31:0] op_address,        // address to core
  output logic             low_freq_optimize, // access mode select
  output logic      [11:0] vector_page_map    // active vector page
);
  localparam logic [31:0] APP_BYTES = 32'(FLASH_KB * 1024);
  localparam bit          BIG_PART  = (FLASH_KB == BIG_KB);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CONTROL) || (a == OFS_ADDRESS) ||
             (a == OFS_COMMAND) || (a == OFS_TRIGGER) ||
             (a == OFS_DF_START) || (a == OFS_ACCESS) ||
             (a == OFS_STATUS);
  endfunction

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] size);
    in_range = (a >= base) && (a < base + size);
  endfunction

  prog_ctrl_t       ctrl, next_ctrl;
  seq_state_t       state, next_state;
  logic             fail, next_fail;
  logic             trigger, next_trigger;
  logic             df_loaded, next_df_loaded;
  logic [31:0]      df_start, next_df_start;
  logic [1:0]       boot_sel, next_boot_sel;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr, next_op_start;
  logic [5:0]       next_op_command;
  logic [31:0]      next_op_address, next_phys;
  logic             next_low_freq;
  logic [11:0]      next_map;
  logic             wr_fire, wr_prot, is_write, in_app, in_ldr, in_cfg;
  logic             err_self, err_cfg, err_addr, any_err;
  logic [31:0]      status_word;

  assign wr_fire = psel && penable && pready && pwrite;
  assign wr_prot = wr_fire && protection_unlock;

  always_comb begin
    status_word = RESET_WORD;
    status_word[MAP_MSB:MAP_LSB] = vector_page_map;        // R8
    status_word[BIT_FAIL] = fail;                          // R13
    status_word[BOOT_MSB:BOOT_LSB] = boot_sel;             // R14
    status_word[BIT_TRIGGER] = trigger;                    // R15 R16
  end

  always_comb begin
    is_write = (op_command == CMD_PROGRAM) || (op_command == CMD_ERASE);
    in_app = op_address < APP_BYTES;
    in_ldr = in_range(op_address, LDR_BASE, LDR_BYTES);
    in_cfg = in_range(op_address, CFG_BASE, CFG_BYTES);
    // self-write only counts when the region's update enable is off
    err_self = is_write && ((in_app && !running_from_loader &&
                             !ctrl.app_update) ||
                            (in_ldr && running_from_loader &&
                             !ctrl.loader_update));           // R9
    err_cfg = is_write && in_cfg && !ctrl.config_update_enable; // R10
    err_addr = !(in_app || in_ldr || in_cfg) ||
               (op_address[1:0] != WORD_OFS0);                 // R11
    if (op_command == CMD_REMAP) begin
      err_addr = !(in_app || in_ldr) ||
                 (op_address[MAP_LSB-1:0] != PAGE_OFS0);       // R19
    end
    any_err = err_self || err_cfg || err_addr;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_trigger = trigger;
    next_df_loaded = df_loaded;
    next_df_start = df_start;
    next_boot_sel = boot_sel;
    next_op_start = 1'b0;
    next_op_command = op_command;
    next_op_address = op_address;
    next_low_freq = low_freq_optimize;
    next_map = vector_page_map;
    next_fail = fail;
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !mapped(paddr);
    next_prdata = prdata;
    // config words settle at power-on; caught once after reset release
    if (!df_loaded) begin
      next_df_loaded = 1'b1;
      next_df_start = BIG_PART ? user_config_word1 : DF_FIXED; // R2 R3
      next_boot_sel = user_config_word0[CFG0_BOOT_LSB +: 2];   // R14
    end
    if (psel && penable && !pready) begin
      case (paddr)
        OFS_CONTROL: begin
          next_prdata = RESET_WORD;
          next_prdata[BIT_FAIL] = fail;                        // R13
          next_prdata[BIT_LDR_UPD] = ctrl.loader_update;
          next_prdata[BIT_CFG_UPD] = ctrl.config_update_enable;
          next_prdata[BIT_APP_UPD] = ctrl.app_update;
          next_prdata[BIT_ENABLE] = ctrl.isp_enable;
        end
        OFS_ADDRESS:  next_prdata = op_address;
        OFS_COMMAND:  next_prdata = {26'h0, op_command};
        OFS_TRIGGER:  next_prdata = {31'h0, trigger};
        OFS_DF_START: next_prdata = df_start;                  // R1
        OFS_ACCESS: begin
          next_prdata = RESET_WORD;
          next_prdata[BIT_LOW_FREQ] = low_freq_optimize;
        end
        OFS_STATUS:   next_prdata = status_word;
        default:      next_prdata = RESET_WORD;
      endcase
    end
    if (wr_fire && (state == ST_IDLE)) begin
      if (paddr == OFS_ADDRESS) begin
        next_op_address = pwdata;
      end
      if (paddr == OFS_COMMAND) begin
        next_op_command = pwdata[CMD_W-1:0];
      end
    end
    if (wr_prot) begin
      if (paddr == OFS_CONTROL) begin
        next_ctrl.loader_update = pwdata[BIT_LDR_UPD];
        next_ctrl.config_update_enable = pwdata[BIT_CFG_UPD];
        next_ctrl.app_update = pwdata[BIT_APP_UPD];
        next_ctrl.isp_enable = pwdata[BIT_ENABLE];
      end
      if (paddr == OFS_ACCESS) begin
        next_low_freq = pwdata[BIT_LOW_FREQ];                  // R4 R6
      end
      if (((paddr == OFS_CONTROL) || (paddr == OFS_STATUS)) &&
          pwdata[BIT_FAIL]) begin
        next_fail = 1'b0;                                      // R12 R13
      end
    end
    case (state)
      ST_IDLE: begin
        if (wr_prot && (paddr == OFS_TRIGGER) && pwdata[BIT_TRIGGER] &&
            ctrl.isp_enable) begin
          next_trigger = 1'b1;                                 // R18
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (any_err) begin
          // the operation never starts; flag wins over a same-cycle clear
          next_fail = 1'b1;                                    // R9 R10 R11
          next_trigger = 1'b0;
          next_state = ST_IDLE;
        end else begin
          next_op_start = 1'b1;
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (op_done) begin
          next_trigger = 1'b0;                                 // R15 R18
          next_state = ST_IDLE;
          if (op_command == CMD_REMAP) begin
            next_map = op_address[MAP_MSB:MAP_LSB];            // R20
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // remap follows the map register, so a new page acts next cycle
    next_phys = fetch_addr;
    if (fetch_addr < VEC_LIMIT) begin
      next_phys = {11'h0, vector_page_map, fetch_addr[MAP_LSB-1:0]}; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl              <= '0;
      state             <= ST_IDLE;
      fail              <= 1'b0;
      trigger           <= 1'b0;
      df_loaded         <= 1'b0;
      df_start          <= RESET_WORD;
      boot_sel          <= 2'h0;
      prdata            <= RESET_WORD;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      op_start          <= 1'b0;
      op_command        <= CMD_READ;
      op_address        <= RESET_WORD;
      flash_phys_addr   <= RESET_WORD;
      low_freq_optimize <= 1'b0;
      vector_page_map   <= MAP_RESET;
    end else if (clk_en) begin
      ctrl              <= next_ctrl;
      state             <= next_state;
      fail              <= next_fail;
      trigger           <= next_trigger;
      df_loaded         <= next_df_loaded;
      df_start          <= next_df_start;
      boot_sel          <= next_boot_sel;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
      op_start          <= next_op_start;
      op_command        <= next_op_command;
      op_address        <= next_op_address;
      flash_phys_addr   <= next_phys;
      low_freq_optimize <= next_low_freq;
      vector_page_map   <= next_map;
    end
  end

  property p_df_ro;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && df_loaded && wr_fire && paddr == OFS_DF_START)
      |=> $stable(df_start);
  endproperty
  a_df_ro: assert property (p_df_ro)                              // R1
    else $error("df start changed");

  // config words are static levels, so the loaded copy must match
  property p_df_fixed;
    @(posedge pclk) disable iff (!presetn)
      df_loaded |->
      (df_start == (BIG_PART ? user_config_word1 : DF_FIXED));
  endproperty
  a_df_fixed: assert property (p_df_fixed)                        // R2 R3
    else $error("df start wrong");

  property p_lfo_locked;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_fire && !protection_unlock && paddr == OFS_ACCESS)
      |=> $stable(low_freq_optimize);
  endproperty
  a_lfo_locked: assert property (p_lfo_locked)                    // R6
    else $error("lfo written while locked");

  property p_remap_addr;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && fetch_addr < VEC_LIMIT) |=>
      (flash_phys_addr == {11'h0, $past(vector_page_map),
                           $past(fetch_addr[MAP_LSB-1:0])});
  endproperty
  a_remap_addr: assert property (p_remap_addr)                    // R7
    else $error("vector fetch not redirected");

  property p_fail_set;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state == ST_CHECK && any_err) |=>
      (fail && !trigger && !op_start);
  endproperty
  a_fail_set: assert property (p_fail_set)                        // R9
    else $error("fail flag not set");

  property p_fail_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_prot && paddr == OFS_STATUS && pwdata[BIT_FAIL] &&
       !(state == ST_CHECK && any_err)) |=> !fail;
  endproperty
  a_fail_clear: assert property (p_fail_clear)                    // R12
    else $error("fail flag not cleared");

  property p_done_clears;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state == ST_BUSY && op_done) |=>
      (!trigger && state == ST_IDLE);
  endproperty
  a_done_clears: assert property (p_done_clears)                  // R18
    else $error("trigger not self-cleared");

  property p_start_pulse;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state == ST_CHECK && !any_err) |=>
      (op_start && trigger) ##1 !op_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)                  // R15
    else $error("start pulse wrong");

  property p_map_load;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && state == ST_BUSY && op_done && op_command == CMD_REMAP)
      |=> (vector_page_map == $past(op_address[MAP_MSB:MAP_LSB]));
  endproperty
  a_map_load: assert property (p_map_load)                        // R20
    else $error("vector map not loaded");

  // read data was captured on the same enabled edge that raised pready
  property p_status_mirror;
    @(posedge pclk) disable iff (!presetn)
      (pready && psel && penable && !pwrite && paddr == OFS_STATUS &&
       $past(clk_en)) |->
      (prdata[BIT_TRIGGER] == $past(trigger)) &&
      (prdata[MAP_MSB:MAP_LSB] == $past(vector_page_map)) &&
      (prdata[BIT_FAIL] == $past(fail));
  endproperty
  a_status_mirror: assert property (p_status_mirror)              // R16
    else $error("status view mismatch");
endmodule

// >>> include/flash_isp_pkg.sv
/*
  Constants and types for the flash programming status/config block.
  Assumes APB byte addresses, 32-bit words, one clock domain.
*/
package flash_isp_pkg;
  localparam logic [7:0]  OFS_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_ADDRESS  = 8'h04;
  localparam logic [7:0]  OFS_COMMAND  = 8'h0C;
  localparam logic [7:0]  OFS_TRIGGER  = 8'h10;
  localparam logic [7:0]  OFS_DF_START = 8'h14;
  localparam logic [7:0]  OFS_ACCESS   = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h40;

  localparam int BIT_ENABLE    = 0;
  localparam int BIT_APP_UPD   = 3;
  localparam int BIT_CFG_UPD   = 4;
  localparam int BIT_LDR_UPD   = 5;
  localparam int BIT_FAIL      = 6;
  localparam int BIT_TRIGGER   = 0;
  localparam int BIT_LOW_FREQ  = 4;
  localparam int MAP_LSB       = 9;
  localparam int MAP_MSB       = 20;
  localparam int BOOT_LSB      = 1;
  localparam int BOOT_MSB      = 2;
  localparam int CFG0_BOOT_LSB = 6;
  localparam int CMD_W         = 6;
  localparam int MAP_W         = 12;

  localparam logic [CMD_W-1:0] CMD_READ    = 6'h00;
  localparam logic [CMD_W-1:0] CMD_READ_ID = 6'h04;
  localparam logic [CMD_W-1:0] CMD_PROGRAM = 6'h21;
  localparam logic [CMD_W-1:0] CMD_ERASE   = 6'h22;
  localparam logic [CMD_W-1:0] CMD_REMAP   = 6'h2E;

  localparam logic [31:0] DF_FIXED    = 32'h0001_F000;
  localparam int          BIG_KB      = 128;
  localparam logic [31:0] LDR_BASE    = 32'h0010_0000;
  localparam logic [31:0] LDR_BYTES   = 32'h0000_1000;
  localparam logic [31:0] CFG_BASE    = 32'h0030_0000;
  localparam logic [31:0] CFG_BYTES   = 32'h0000_0008;
  localparam logic [31:0] VEC_LIMIT   = 32'h0000_0200;
  localparam logic [8:0]  PAGE_OFS0   = 9'h000;
  localparam logic [1:0]  WORD_OFS0   = 2'h0;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [MAP_W-1:0] MAP_RESET = 12'h000;

  typedef struct packed {
    logic loader_update;
    logic config_update_enable;
    logic app_update;
    logic isp_enable;
  } prog_ctrl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_BUSY} seq_state_t;
endpackage

// >>> verif/flash_isp_status_regs_test.sv
/*
  Self-checking bench for the flash programming status/config block.
  Assumes the APB slave answers in its own time; bench plays flash core.
*/
`timescale 1ns/1ns
module flash_isp_status_regs_test;
  import flash_isp_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, unlock;
  logic        from_ldr, op_done = 1'b0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, cfg0, cfg1, fetch_addr, prdata, phys, op_address;
  logic        pready, pslverr, op_start, low_freq;
  logic [5:0]  op_command, exp_cmd;
  logic [11:0] vmap, exp_map;
  logic [31:0] rd, exp_adr, a, off;
  logic        er, exp_fail;
  int          n_fail, total_checks, n0;
  int          dly = 0;
  int          n_start = 0;

  flash_isp_status_regs #(.FLASH_KB(128)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .protection_unlock(unlock), .user_config_word0(cfg0),
    .user_config_word1(cfg1), .running_from_loader(from_ldr),
    .op_done(op_done), .fetch_addr(fetch_addr), .flash_phys_addr(phys),
    .op_start(op_start), .op_command(op_command), .op_address(op_address),
    .low_freq_optimize(low_freq), .vector_page_map(vmap));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] st_exp(input logic trig);
    return {11'h0, exp_map, 2'h0, exp_fail, 3'h0,
            cfg0[CFG0_BOOT_LSB+:2], trig};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  // pready, prdata and pslverr taken at the rising edge that ends access
  task automatic apb(input logic [7:0] ad, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= ad;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (!got && n < 20) begin
      @(posedge pclk);
      got = (pready === 1'b1);
      r = prdata;
      e = pslverr;
      n++;
    end
    if (!got) chk_pin({31'h0, got}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d, rd, er);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(ad, 1'b0, 32'h0, rd, er);
    chk_reg(rd, exp);
  endtask

  task automatic do_op(input logic [5:0] c, input logic [31:0] ad,
                       input logic ok);
    int i;
    exp_cmd = c;
    exp_adr = ad;
    wr(OFS_COMMAND, {26'h0, c});
    wr(OFS_ADDRESS, ad);
    wr(OFS_TRIGGER, 32'h1);
    if (ok) rdchk(OFS_STATUS, st_exp(1'b1));
    for (i = 0; i < 20; i++) begin
      apb(OFS_STATUS, 1'b0, 32'h0, rd, er);
      if (rd[0] === 1'b0) break;
    end
  endtask

  // flash core stand-in: answers each start after a few cycles
  always @(posedge pclk) begin
    op_done <= (dly == 1);
    if (op_start === 1'b1) begin
      dly <= 5;
      n_start <= n_start + 1;
      chk_pin({26'h0, op_command}, {26'h0, exp_cmd});
      chk_pin(op_address, exp_adr);
    end else if (dly > 0) begin
      dly <= dly - 1;
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h3c879384));
    {presetn, psel, penable, pwrite, unlock, from_ldr} = 6'h00;
    clk_en = 1'b1;
    {paddr, pwdata, fetch_addr} = '0;
    {n_fail, total_checks} = '0;
    exp_fail = 1'b0;
    exp_map = 12'h000;
    exp_cmd = 6'h00;
    exp_adr = 32'h0;
    cfg0 = $urandom;
    cfg1 = $urandom;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_DF_START, cfg1);
    rdchk(OFS_ACCESS, 32'h0);
    rdchk(OFS_STATUS, st_exp(1'b0));
    wr(OFS_DF_START, ~cfg1);
    rdchk(OFS_DF_START, cfg1);
    apb(8'h08, 1'b0, 32'h0, rd, er);
    chk_reg({rd[31:1], er}, 32'h1);
    $display("test reset_and_ro done");

    wr(OFS_ACCESS, 32'h10);
    rdchk(OFS_ACCESS, 32'h0);
    chk_pin({31'h0, low_freq}, 32'h0);
    unlock <= 1'b1;
    // software alone judges whether the chip clock is slow enough
    wr(OFS_ACCESS, 32'h10);
    rdchk(OFS_ACCESS, 32'h10);
    chk_pin({31'h0, low_freq}, 32'h1);
    wr(OFS_ACCESS, 32'h0);
    @(negedge pclk);
    chk_pin({31'h0, low_freq}, 32'h0);
    $display("test low_freq done");

    wr(OFS_CONTROL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      n0 = n_start;
      from_ldr <= (i == 3);
      a = (i == 0) ? ($urandom_range(0, 32767) << 2) :
          (i == 1) ? CFG_BASE :
          (i == 2) ? 32'h0020_0000 : LDR_BASE;
      do_op((i == 1) ? CMD_ERASE : CMD_PROGRAM, a, 1'b0);
      exp_fail = 1'b1;
      rdchk(OFS_STATUS, st_exp(1'b0));
      rdchk(OFS_CONTROL, 32'h41);
      chk_reg(32'(n_start), 32'(n0));
      if (i == 0) begin
        unlock <= 1'b0;
        wr(OFS_STATUS, 32'h40);
        rdchk(OFS_STATUS, st_exp(1'b0));
        unlock <= 1'b1;
      end
      wr((i == 1) ? OFS_CONTROL : OFS_STATUS, 32'h41);
      exp_fail = 1'b0;
      rdchk(OFS_CONTROL, 32'h01);
    end
    from_ldr <= 1'b0;
    do_op(CMD_READ, 32'h0, 1'b1);
    rdchk(OFS_STATUS, st_exp(1'b0));
    $display("test fail_flag done");

    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? LDR_BASE + (32'($urandom_range(0, 7)) << 9) :
          (32'($urandom_range(1, 255)) << 9);
      do_op(CMD_REMAP, a, 1'b1);
      exp_map = a[MAP_MSB:MAP_LSB];
      rdchk(OFS_STATUS, st_exp(1'b0));
      chk_pin({20'h0, vmap}, {20'h0, exp_map});
      wr(OFS_STATUS, 32'h001F_FE00);
      rdchk(OFS_STATUS, st_exp(1'b0));
      off = 32'($urandom_range(0, 511));
      fetch_addr <= off;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk_pin(phys, {11'h0, exp_map, off[8:0]});
      fetch_addr <= off + 32'h400;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk_pin(phys, off + 32'h400);
    end
    // clock enable low must freeze the remapped address register
    @(posedge pclk);
    clk_en <= 1'b0;
    fetch_addr <= off;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk_pin(phys, off + 32'h400);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk_pin(phys, {11'h0, exp_map, off[8:0]});
    $display("test remap done");
    finish_test();
  end
endmodule
